// >>> common/e1_slip_cas_defines.vh
`ifndef E1_SLIP_CAS_DEFINES_VH
`define E1_SLIP_CAS_DEFINES_VH

// Register byte offsets (8-bit register space)
`define ADDR_TX_SLIP_STATUS   8'h6c
`define ADDR_TX_SLIP_MASK     8'h29
`define ADDR_RX_SLIP_STATUS   8'h6b
`define ADDR_RX_SLIP_MASK     8'h17
`define ADDR_CAS_STATUS       8'h68
`define ADDR_CAS_MASK         8'h14
`define ADDR_GLOBAL_PENDING   8'h6e
`define ADDR_IRQ_CONFIG       8'h08
`define ADDR_REVISION         8'h4a
`define ADDR_SIG_BASE         8'h70
`define ADDR_SIG_LAST         8'h7f

// Bit positions
`define BIT_TX_SLIP_POS       7
`define BIT_TX_SLIP_NEG       6
`define BIT_RX_SLIP_POS       0
`define BIT_RX_SLIP_NEG       1
`define BIT_CAS_CHANGE        3
`define BIT_VIS               7
`define BIT_GP_ISR0           0
`define BIT_GP_ISR3           3
`define BIT_GP_TX_SLIP_EVENT_STATUS           5

// Reset values
`define RST_BYTE              8'h00
`define RST_IRQ_CONFIG        8'h01
`define ZERO_NIBBLE           4'h0

// Signaling multiframe
`define SIG_REGS              16
`define SIG_IDX_W             4

`endif

// >>> core/e1_slip_cas_status.v
// Function
// - Set rx positive slip on slower line clock
// - Rx positive slip repeats one buffered frame
// - Reading tx slip status clears both tx flags
// - Masked visible flags never interrupt or pend
// - Set tx positive slip on slower tx clock
// - Tx positive slip drops one whole frame
// - Tx negative slip flag; frame repeated
// - Global pointer shows pending unmasked sources
// - Read-only eight-bit silicon revision code
// - Slot n upper, slot n+15 lower, ABCD
// - Multiframe differs from previous: raise change flag
// - First register: zeros, spare, alarm, spares
// - Earliest received bit sits in MSB
// - Signaling registers not reset, undefined
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "e1_slip_cas_defines.vh"

module e1_slip_cas_status #(
    parameter [7:0] REVISION_CODE = 8'h5a  // Arbitrary value
) (
    CLK,
    RESET,
    ADDR,
    WDATA,
    WR,
    RD,
    RDATA,
    RX_SLIP_POS_EV,
    RX_SLIP_NEG_EV,
    RX_ALARM_SIM,
    TX_SLIP_POS_EV,
    TX_SLIP_NEG_EV,
    TWO_FRAME_MODE,
    MF_VALID,
    MF_DATA,
    RX_REPEAT_FRAME,
    TX_DROP_FRAME,
    TX_REPEAT_FRAME,
    IRQ
);
    input  wire         CLK;
    input  wire         RESET;
    input  wire [7:0]   ADDR;
    input  wire [7:0]   WDATA;
    input  wire         WR;
    input  wire         RD;
    output reg  [7:0]   RDATA;
    input  wire         RX_SLIP_POS_EV;
    input  wire         RX_SLIP_NEG_EV;
    input  wire         RX_ALARM_SIM;
    input  wire         TX_SLIP_POS_EV;
    input  wire         TX_SLIP_NEG_EV;
    input  wire         TWO_FRAME_MODE;
    input  wire         MF_VALID;
    input  wire [127:0] MF_DATA;
    output reg          RX_REPEAT_FRAME;
    output reg          TX_DROP_FRAME;
    output reg          TX_REPEAT_FRAME;
    output wire         IRQ;

    reg  [7:0]   tx_mask_q;
    reg  [7:0]   rx_mask_q;
    reg  [7:0]   cas_mask_q;
    reg  [7:0]   irq_cfg_q;
    reg          tx_pos_q;
    reg          tx_neg_q;
    reg          rx_pos_q;
    reg          rx_neg_q;
    reg          cas_chg_q;
    reg          have_mf_q;
    reg  [7:0]   sig_q [0:`SIG_REGS-1];
    wire [127:0] mf_flat;
    wire         rd_tx;
    wire         rd_rx;
    wire         rd_cas;
    wire         vis;
    wire         rx_pos_ev;
    wire         mf_changed;
    wire [7:0]   tx_raw;
    wire [7:0]   rx_raw;
    wire [7:0]   cas_raw;
    wire [7:0]   tx_pend;
    wire [7:0]   rx_pend;
    wire [7:0]   cas_pend;
    wire [7:0]   global_ptr;
    reg  [7:0]   rdata_d;

    assign rd_tx  = RD && (ADDR == `ADDR_TX_SLIP_STATUS);
    assign rd_rx  = RD && (ADDR == `ADDR_RX_SLIP_STATUS);
    assign rd_cas = RD && (ADDR == `ADDR_CAS_STATUS);
    assign vis    = irq_cfg_q[`BIT_VIS];

    // Alarm simulation sets the positive receive slip flag (no frame repeat)
    assign rx_pos_ev = RX_SLIP_POS_EV | RX_ALARM_SIM;

    // Raw flag vectors in their register layout
    assign tx_raw  = {tx_pos_q, tx_neg_q, 6'h00};
    assign rx_raw  = {6'h00, rx_neg_q, rx_pos_q};
    assign cas_raw = {4'h0, cas_chg_q, 3'h0};
    assign tx_pend  = tx_raw & tx_mask_q;
    assign rx_pend  = rx_raw & rx_mask_q;
    assign cas_pend = cas_raw & cas_mask_q;

    // Only unmasked sources reach the pointer and the pin
    assign global_ptr = {2'h0, |tx_pend, 1'b0, |rx_pend, 2'h0, |cas_pend};
    assign IRQ = |global_ptr;

    // Flatten incoming multiframe into register order for comparison
    genvar g;
    generate
        for (g = 0; g < `SIG_REGS; g = g + 1) begin : g_flat
            assign mf_flat[g*8 +: 8] = (g == 0) ?
                {`ZERO_NIBBLE, MF_DATA[3:0]} :
                MF_DATA[g*8 +: 8];
        end
    endgenerate

    // Any differing byte counts as a change
    wire [`SIG_REGS-1:0] diff;
    generate
        for (g = 0; g < `SIG_REGS; g = g + 1) begin : g_diff
            assign diff[g] = (sig_q[g] != mf_flat[g*8 +: 8]);
        end
    endgenerate
    assign mf_changed = MF_VALID && have_mf_q && (|diff);

    // Signaling store has no reset; content undefined until first multiframe
    generate
        for (g = 0; g < `SIG_REGS; g = g + 1) begin : g_sig
            always @(posedge CLK) begin
                if (MF_VALID) begin
                    sig_q[g] <= mf_flat[g*8 +: 8];
                end
            end
        end
    endgenerate

    // Sticky flags; an event in the clearing cycle survives
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tx_pos_q  <= 1'b0;
            tx_neg_q  <= 1'b0;
            rx_pos_q  <= 1'b0;
            rx_neg_q  <= 1'b0;
            cas_chg_q <= 1'b0;
            have_mf_q <= 1'b0;
        end else begin
            tx_pos_q  <= TX_SLIP_POS_EV | (tx_pos_q & ~rd_tx);
            tx_neg_q  <= TX_SLIP_NEG_EV | (tx_neg_q & ~rd_tx);
            rx_pos_q  <= rx_pos_ev | (rx_pos_q & ~rd_rx);
            rx_neg_q  <= RX_SLIP_NEG_EV | (rx_neg_q & ~rd_rx);
            cas_chg_q <= mf_changed | (cas_chg_q & ~rd_cas);
            if (MF_VALID) begin
                have_mf_q <= 1'b1;
            end
        end
    end

    // Buffer actions only in two-frame mode; one-cycle commands
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            RX_REPEAT_FRAME <= 1'b0;
            TX_DROP_FRAME   <= 1'b0;
            TX_REPEAT_FRAME <= 1'b0;
        end else begin
            RX_REPEAT_FRAME <= TWO_FRAME_MODE & RX_SLIP_POS_EV;
            TX_DROP_FRAME   <= TWO_FRAME_MODE & TX_SLIP_POS_EV;
            TX_REPEAT_FRAME <= TWO_FRAME_MODE & TX_SLIP_NEG_EV;
        end
    end

    // Writable mask and configuration registers
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tx_mask_q  <= `RST_BYTE;
            rx_mask_q  <= `RST_BYTE;
            cas_mask_q <= `RST_BYTE;
            irq_cfg_q  <= `RST_IRQ_CONFIG;
        end else if (WR) begin
            case (ADDR)
                `ADDR_TX_SLIP_MASK: begin
                    tx_mask_q <= WDATA;
                end
                `ADDR_RX_SLIP_MASK: begin
                    rx_mask_q <= WDATA;
                end
                `ADDR_CAS_MASK: begin
                    cas_mask_q <= WDATA;
                end
                `ADDR_IRQ_CONFIG: begin
                    irq_cfg_q <= WDATA;
                end
                default: begin
                    irq_cfg_q <= irq_cfg_q;
                end
            endcase
        end
    end

    // Read mux; masked flags shown only when visibility is on
    always @* begin
        rdata_d = `RST_BYTE;
        // Bounded on both ends so addresses above the store never alias into it
        if ((ADDR >= `ADDR_SIG_BASE) && (ADDR <= `ADDR_SIG_LAST)) begin
            rdata_d = sig_q[ADDR[`SIG_IDX_W-1:0]];
        end else begin
            case (ADDR)
                `ADDR_TX_SLIP_STATUS: rdata_d = vis ? tx_raw : tx_pend;
                `ADDR_RX_SLIP_STATUS: rdata_d = vis ? rx_raw : rx_pend;
                `ADDR_CAS_STATUS:     rdata_d = vis ? cas_raw : cas_pend;
                `ADDR_TX_SLIP_MASK:   rdata_d = tx_mask_q;
                `ADDR_RX_SLIP_MASK:   rdata_d = rx_mask_q;
                `ADDR_CAS_MASK:       rdata_d = cas_mask_q;
                `ADDR_IRQ_CONFIG:     rdata_d = irq_cfg_q;
                `ADDR_GLOBAL_PENDING: rdata_d = global_ptr;
                `ADDR_REVISION:       rdata_d = REVISION_CODE;
                default:              rdata_d = `RST_BYTE;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= `RST_BYTE;
        end else begin
            RDATA <= RD ? rdata_d : `RST_BYTE;
        end
    end

endmodule // e1_slip_cas_status

// >>> dv/e1_slip_cas_asserts.sv
`timescale 1ns/10ps
module e1_slip_cas_asserts #(
    parameter [7:0] REVISION_CODE = 8'h5a
) (
    input wire       CLK,
    input wire       RESET,
    input wire [7:0] ADDR,
    input wire       RD,
    input wire [7:0] RDATA,
    input wire       RX_SLIP_POS_EV,
    input wire       TX_SLIP_POS_EV,
    input wire       TX_SLIP_NEG_EV,
    input wire       TWO_FRAME_MODE,
    input wire       MF_VALID,
    input wire       RX_REPEAT_FRAME,
    input wire       TX_DROP_FRAME,
    input wire       TX_REPEAT_FRAME
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Store is undefined until a multiframe lands
    reg seen_q;
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_q | MF_VALID;
        end
    end
    sequence s_clr_rd;
        RD && ADDR == 8'h6c && !TX_SLIP_POS_EV && !TX_SLIP_NEG_EV;
    endsequence
    a_clear_on_read: assert property (s_clr_rd ##1 !(TX_SLIP_POS_EV || TX_SLIP_NEG_EV) ##1 s_clr_rd |=> RDATA == 8'h00)
        else $error("status kept after read");
    a_drop_on_pos: assert property (TX_SLIP_POS_EV && TWO_FRAME_MODE |=> TX_DROP_FRAME) else $error("no drop");
    a_drop_only_pos: assert property (!(TX_SLIP_POS_EV && TWO_FRAME_MODE) |=> !TX_DROP_FRAME) else $error("drop");
    a_rep_on_neg: assert property (TX_SLIP_NEG_EV && TWO_FRAME_MODE |=> TX_REPEAT_FRAME) else $error("no repeat");
    a_rep_only_neg: assert property (!(TX_SLIP_NEG_EV && TWO_FRAME_MODE) |=> !TX_REPEAT_FRAME) else $error("repeat");
    a_rx_repeat: assert property (RX_SLIP_POS_EV && TWO_FRAME_MODE |=> RX_REPEAT_FRAME) else $error("no rx repeat");
    a_revision_code: assert property (RD && ADDR == 8'h4a |=> RDATA == REVISION_CODE) else $error("bad code");
    a_frame0_zeros: assert property (seen_q && RD && ADDR == 8'h70 |=> RDATA[7:4] == 4'h0) else $error("nibble");
endmodule // e1_slip_cas_asserts

bind e1_slip_cas_status e1_slip_cas_asserts #(.REVISION_CODE(REVISION_CODE)) i_chk (.CLK, .RESET, .ADDR, .RD, .RDATA,
    .RX_SLIP_POS_EV, .TX_SLIP_POS_EV, .TX_SLIP_NEG_EV, .TWO_FRAME_MODE, .MF_VALID, .RX_REPEAT_FRAME, .TX_DROP_FRAME,
    .TX_REPEAT_FRAME);

// >>> dv/test_e1_slip_cas_status.sv
`timescale 1ns/10ps
module test_e1_slip_cas_status;
    localparam [7:0]   REV = 8'h3c;  // Arbitrary value
    localparam [127:0] MFA = 128'hfedcba98_76543210_0f1e2d3c_4b5a6978;
    localparam [127:0] MFB = MFA ^ 128'h100000;
    reg                clk, rst, wr, rd, alarm, two, mfv;
    reg        [7:0]   addr, wdata;
    reg        [3:0]   ev;
    reg        [127:0] mf;
    wire       [7:0]   rdata;
    wire               irq;
    integer            miscompares, total_checks, i;

    e1_slip_cas_status #(.REVISION_CODE(REV)) i_dut (.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RX_SLIP_POS_EV(ev[0]), .RX_SLIP_NEG_EV(ev[1]), .RX_ALARM_SIM(alarm),
        .TX_SLIP_POS_EV(ev[2]), .TX_SLIP_NEG_EV(ev[3]), .TWO_FRAME_MODE(two), .MF_VALID(mfv), .MF_DATA(mf),
        .RX_REPEAT_FRAME(), .TX_DROP_FRAME(), .TX_REPEAT_FRAME(), .IRQ(irq));

    task chk(input string nm, input [7:0] e, input [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    // Read data live only in the cycle after the strobe
    task rreg(input [7:0] a, input [7:0] e);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) chk("read data", e, rdata);
    endtask
    task pulse(input [3:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 4'h0;
    endtask
    task chk_irq(input e);
        @(negedge clk) chk("irq", {7'h0, e}, {7'h0, irq});
    endtask
    task mframe(input [127:0] d);
        @(posedge clk) begin mf <= d; mfv <= 1'b1; end
        @(posedge clk) mfv <= 1'b0;
    endtask
    task t_idle;
        rreg(8'h6e, 8'h00);
        wreg(8'h4a, 8'hff);
        rreg(8'h4a, REV);
    endtask
    task t_tx;
        wreg(8'h29, 8'hc0);
        pulse(4'h4);
        chk_irq(1'b1);
        rreg(8'h6e, 8'h20);
        rreg(8'h6c, 8'h80);
        rreg(8'h6c, 8'h00);
        chk_irq(1'b0);
        pulse(4'h8);
        rreg(8'h6c, 8'h40);
        // Event in the very cycle of the clearing read
        @(posedge clk) begin addr <= 8'h6c; rd <= 1'b1; ev <= 4'h4; end
        @(posedge clk) begin rd <= 1'b0; ev <= 4'h0; end
        rreg(8'h6c, 8'h80);
    endtask
    task t_vis;
        wreg(8'h29, 8'h00);
        two <= 1'b0;
        wreg(8'h08, 8'h81);
        pulse(4'hc);
        chk_irq(1'b0);
        rreg(8'h6e, 8'h00);
        rreg(8'h6c, 8'hc0);
        wreg(8'h08, 8'h01);
        two <= 1'b1;
    endtask
    task t_rx;
        wreg(8'h17, 8'h01);
        pulse(4'h1);
        rreg(8'h6e, 8'h08);
        rreg(8'h6b, 8'h01);
        @(posedge clk) alarm <= 1'b1;
        @(posedge clk) alarm <= 1'b0;
        rreg(8'h6b, 8'h01);
        // Negative slip stays hidden while masked and not visible
        pulse(4'h2);
        rreg(8'h6b, 8'h00);
        wreg(8'h17, 8'h03);
        pulse(4'h2);
        rreg(8'h6b, 8'h02);
    endtask
    // Mid-run reset returns tx slip mask, config and pin to their reset state
    task t_reset;
        wreg(8'h29, 8'hc0);
        pulse(4'h4);
        chk_irq(1'b1);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        chk_irq(1'b0);
        rreg(8'h29, 8'h00);
        rreg(8'h08, 8'h01);
        rreg(8'h6e, 8'h00);
    endtask
    task t_cas;
        wreg(8'h14, 8'h08);
        mframe(MFA);
        // Whole readout well inside one multiframe period
        for (i = 0; i < 16; i = i + 1) rreg(8'h70 + i[7:0], i == 0 ? {4'h0, MFA[3:0]} : MFA[i*8 +: 8]);
        rreg(8'h68, 8'h00);
        mframe(MFA);
        rreg(8'h68, 8'h00);
        mframe(MFB);
        chk_irq(1'b1);
        rreg(8'h6e, 8'h01);
        rreg(8'h68, 8'h08);
    endtask
    task wrap_up;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run is about 120 cycles
    initial begin
        #200000;
        miscompares = miscompares + 1;
        wrap_up;
    end
    initial begin
        {rst, wr, rd, alarm, mfv, ev, addr, wdata, mf} = 0;
        two = 1'b1;
        miscompares = 0;
        total_checks = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_idle;
        t_tx;
        t_vis;
        t_rx;
        t_cas;
        t_reset;
        wrap_up;
    end
endmodule // test_e1_slip_cas_status
